// File: core/ast_defs.svh
// register map, field positions, reset values and timing counts of the serial transmitter
`ifndef AST_DEFS_SVH
`define AST_DEFS_SVH

// register indices; the byte address is four times the index
`define AST_IDX_INTERRUPT_CONTROL 10'h00b
`define AST_IDX_PERIPHERAL_INT_FLAGS 10'h00c
`define AST_IDX_RECEIVE_STATUS_CONTROL 10'h018
`define AST_IDX_TRANSMIT_HOLDING 10'h019
`define AST_IDX_PERIPHERAL_INT_ENABLES 10'h08c
`define AST_IDX_TRANSMIT_STATUS_CONTROL 10'h098
`define AST_IDX_BAUD_DIVISOR 10'h099

// field positions
`define AST_BIT_GLOBAL_INT_ENABLE 7
`define AST_BIT_PERIPHERAL_INT_ENABLE 6
`define AST_BIT_TX_INT_FLAG 4
`define AST_BIT_TX_INT_ENABLE 4
`define AST_BIT_SERIAL_PORT_ENABLE 7
`define AST_BIT_NINE_BIT_TX_SELECT 6
`define AST_BIT_TX_ENABLE 5
`define AST_BIT_SYNC_SELECT 4
`define AST_BIT_HIGH_SPEED_SELECT 2
`define AST_BIT_TX_SHIFT_EMPTY 1
`define AST_BIT_TX_NINTH_BIT 0

// reset values
`define AST_RST_INTERRUPT_CONTROL 8'h00
`define AST_RST_PERIPHERAL_INT_FLAGS 8'h00
`define AST_RST_RECEIVE_STATUS_CONTROL 8'h00
`define AST_RST_PERIPHERAL_INT_ENABLES 8'h00
`define AST_RST_TRANSMIT_STATUS_CONTROL 8'h02
`define AST_RST_BAUD_DIVISOR 8'h00

// writable bits; the rest are hardware status or unimplemented
`define AST_WMASK_PERIPHERAL_INT_FLAGS 8'hef
`define AST_WMASK_RECEIVE_STATUS_CONTROL 8'hf0
`define AST_WMASK_TRANSMIT_STATUS_CONTROL 8'hf5

// divisor ticks per bit, minus one, for each range
`define AST_TICKS_LAST_NORMAL 6'h3f
`define AST_TICKS_LAST_FAST 6'h0f

// bits sent after the start bit: nine-bit and eight-bit frames
`define AST_BITS_LEFT_NINE 4'ha
`define AST_BITS_LEFT_EIGHT 4'h9

// transmit buffer shape
`define AST_FIFO_WIDTH 9
`define AST_FIFO_DEPTH 4

`endif

// File: core/ast_pkg.sv
// types shared by the serial transmitter modules
package ast_pkg;

  // transmit shifter state
  typedef enum logic [0:0] {
    AST_ST_IDLE = 1'b0,
    AST_ST_SEND = 1'b1
  } ast_tx_state_t;

  // one register byte
  typedef logic [7:0] ast_byte_t;

endpackage

// File: core/ast_stream_if.sv
// valid/ready word stream between the register side, the buffer and the shifter
`timescale 1ns/1ps
interface ast_stream_if #(parameter int W = 9);
  logic valid; // word offered
  logic ready; // word accepted when valid is high too
  logic [W-1:0] data; // the word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: core/ast_fifo.sv
// small first-in first-out buffer with valid/ready on both sides
`timescale 1ns/1ps
module ast_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic reset_i,
  ast_stream_if.snk in_s,
  ast_stream_if.src out_s
);
  // depth must be a power of two; pointers carry one wrap bit
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH]; // storage words
  logic [AW:0] wp_r; // write pointer with wrap bit
  logic [AW:0] rp_r; // read pointer with wrap bit

  wire logic full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  wire logic empty = (wp_r == rp_r);
  wire logic push = in_s.valid & ~full;
  wire logic pop = out_s.ready & ~empty;

  // handshake toward both sides
  assign in_s.ready = ~full;
  assign out_s.valid = ~empty;
  assign out_s.data = mem_r[rp_r[AW-1:0]];

  // pointer update
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end

  // storage words, one process per slot
  for (genvar g = 0; g < DEPTH; g++) begin : g_slot
    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        mem_r[g] <= '0;
      end else if (push && (wp_r[AW-1:0] == AW'(g))) begin
        mem_r[g] <= in_s.data;
      end
    end
  end
endmodule

// File: core/ast_top.sv
// asynchronous serial transmitter with its registers on an APB slave port
`timescale 1ns/1ps
`include "ast_defs.svh"
module ast_top (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic tx_o,
  output logic tx_oe_o,
  output logic tx_int_o
);

  // bus decode
  // a transfer completes in its access cycle; no wait states are inserted
  // only aligned words at a register index hit; anything else is refused

  // true when a byte address lands on the word of a register index
  function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
    return (addr[1:0] == 2'h0) && (addr[11:2] == idx);
  endfunction

  wire logic bus_setup = psel_i & ~penable_i; // first cycle of a transfer
  wire logic bus_access = psel_i & penable_i; // completing cycle, no wait states
  wire logic bus_wr = bus_access & pwrite_i; // write takes effect here
  wire ast_pkg::ast_byte_t wr_byte = pwdata_i[7:0]; // only the low byte is stored

  // one hit per register
  wire logic hit_intctl = reg_hit(paddr_i, `AST_IDX_INTERRUPT_CONTROL);
  wire logic hit_pirf = reg_hit(paddr_i, `AST_IDX_PERIPHERAL_INT_FLAGS);
  wire logic hit_receive_status_control = reg_hit(paddr_i, `AST_IDX_RECEIVE_STATUS_CONTROL);
  wire logic hit_hold = reg_hit(paddr_i, `AST_IDX_TRANSMIT_HOLDING);
  wire logic hit_pie = reg_hit(paddr_i, `AST_IDX_PERIPHERAL_INT_ENABLES);
  wire logic hit_transmit_status_control = reg_hit(paddr_i, `AST_IDX_TRANSMIT_STATUS_CONTROL);
  wire logic hit_baud = reg_hit(paddr_i, `AST_IDX_BAUD_DIVISOR);
  wire logic hit_any = hit_intctl | hit_pirf | hit_receive_status_control | hit_hold | hit_pie |
                       hit_transmit_status_control | hit_baud;

  // write strobes
  wire logic wr_intctl = bus_wr & hit_intctl;
  wire logic wr_pirf = bus_wr & hit_pirf;
  wire logic wr_receive_status_control = bus_wr & hit_receive_status_control;
  wire logic wr_hold = bus_wr & hit_hold;
  wire logic wr_pie = bus_wr & hit_pie;
  wire logic wr_transmit_status_control = bus_wr & hit_transmit_status_control;
  wire logic wr_baud = bus_wr & hit_baud;

  // software registers
  // each register stores only its writable bits so unimplemented ones read zero
  // hardware-owned status stays outside these flops and is merged on read

  ast_pkg::ast_byte_t intctl_r; // interrupt_control, fully writable
  ast_pkg::ast_byte_t pirf_r; // peripheral_int_flags, software bits only
  ast_pkg::ast_byte_t receive_status_control_r; // receive_status_control, control bits only
  ast_pkg::ast_byte_t pie_r; // peripheral_int_enables
  ast_pkg::ast_byte_t transmit_status_control_r; // transmit_status_control, software bits only
  ast_pkg::ast_byte_t baud_r; // baud_divisor
  logic flag_r; // tx_int_flag, owned by hardware
  logic [31:0] prdata_r; // read data captured in the setup cycle

  // interrupt_control
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      intctl_r <= `AST_RST_INTERRUPT_CONTROL;
    end else if (wr_intctl) begin
      intctl_r <= wr_byte;
    end
  end

  // peripheral_int_flags: the transmit flag bit is read-only here
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pirf_r <= `AST_RST_PERIPHERAL_INT_FLAGS;
    end else if (wr_pirf) begin
      pirf_r <= wr_byte & `AST_WMASK_PERIPHERAL_INT_FLAGS;
    end
  end

  // receive_status_control: only the enable and receiver control bits store
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      receive_status_control_r <= `AST_RST_RECEIVE_STATUS_CONTROL;
    end else if (wr_receive_status_control) begin
      receive_status_control_r <= wr_byte & `AST_WMASK_RECEIVE_STATUS_CONTROL;
    end
  end

  // peripheral_int_enables
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pie_r <= `AST_RST_PERIPHERAL_INT_ENABLES;
    end else if (wr_pie) begin
      pie_r <= wr_byte;
    end
  end

  // transmit_status_control: the empty bit and bit 3 never store
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      transmit_status_control_r <= `AST_RST_TRANSMIT_STATUS_CONTROL & `AST_WMASK_TRANSMIT_STATUS_CONTROL;
    end else if (wr_transmit_status_control) begin
      transmit_status_control_r <= wr_byte & `AST_WMASK_TRANSMIT_STATUS_CONTROL;
    end
  end

  // baud_divisor; software sets it before enabling, a change mid-frame
  // takes effect at the next divisor reload
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      baud_r <= `AST_RST_BAUD_DIVISOR;
    end else if (wr_baud) begin
      baud_r <= wr_byte;
    end
  end

  // control fields
  // named taps on the stored bits keep the datapath free of field positions
  // the shifter runs only in asynchronous mode with the transmitter enabled

  wire logic port_en = receive_status_control_r[`AST_BIT_SERIAL_PORT_ENABLE];
  wire logic sync_sel = transmit_status_control_r[`AST_BIT_SYNC_SELECT];
  wire logic tx_en = transmit_status_control_r[`AST_BIT_TX_ENABLE];
  wire logic fast_sel = transmit_status_control_r[`AST_BIT_HIGH_SPEED_SELECT];
  wire logic nine_sel = transmit_status_control_r[`AST_BIT_NINE_BIT_TX_SELECT];
  wire logic ninth_bit = transmit_status_control_r[`AST_BIT_TX_NINTH_BIT];

  // the port runs asynchronously only when enabled and not synchronous
  wire logic port_async = port_en & ~sync_sel;
  wire logic tx_run = port_async & tx_en;

  // transmit enable going from clear to set
  wire logic tx_en_rise = wr_transmit_status_control & wr_byte[`AST_BIT_TX_ENABLE] & ~tx_en;

  // holding buffer
  // bytes queue here so software may write ahead of the line
  // a write to a full buffer is refused rather than overwriting queued data

  ast_stream_if #(.W(`AST_FIFO_WIDTH)) hold_s (); // bus into buffer
  ast_stream_if #(.W(`AST_FIFO_WIDTH)) shift_s (); // buffer into shifter

  // a holding write queues the byte with the ninth bit already stored
  assign hold_s.valid = wr_hold;
  assign hold_s.data = {ninth_bit, wr_byte};
  wire logic hold_take = wr_hold & hold_s.ready; // byte accepted

  ast_fifo #(
    .WIDTH(`AST_FIFO_WIDTH),
    .DEPTH(`AST_FIFO_DEPTH)
  ) u_hold (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_s(hold_s),
    .out_s(shift_s)
  );

  // baud generator and shifter
  // the divisor counter makes ticks and the tick counter groups them into bits
  // both restart at each load so every frame starts on a whole bit

  ast_pkg::ast_tx_state_t state_r; // shifter state
  logic [7:0] div_cnt_r; // counts divisor+1 clocks per tick
  logic [5:0] tick_cnt_r; // counts ticks within one bit
  logic [9:0] shreg_r; // bits still to send after the current one
  logic [3:0] left_r; // number of bits still to send
  logic tx_r; // line level

  // a bit lasts 64 or 16 ticks of divisor+1 clocks each
  wire logic [5:0] tick_last = fast_sel ? `AST_TICKS_LAST_FAST : `AST_TICKS_LAST_NORMAL;
  wire logic sending = (state_r == ast_pkg::AST_ST_SEND);
  wire logic div_tick = sending & (div_cnt_r == 8'h00);
  wire logic bit_end = div_tick & (tick_cnt_r == tick_last);
  wire logic frame_done = bit_end & (left_r == 4'h0); // stop bit finished

  // a new byte is taken when idle or right at the end of a stop bit
  assign shift_s.ready = tx_run & (~sending | frame_done);
  wire logic load = shift_s.ready & shift_s.valid;

  // divisor counter: reload after each tick, held at the divisor while idle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt_r <= 8'h00;
    end else if (!sending || div_tick) begin
      div_cnt_r <= baud_r;
    end else begin
      div_cnt_r <= div_cnt_r - 8'h01;
    end
  end

  // tick counter: restarts with each frame and each bit
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tick_cnt_r <= 6'h00;
    end else if (!sending || bit_end) begin
      tick_cnt_r <= 6'h00;
    end else if (div_tick) begin
      tick_cnt_r <= tick_cnt_r + 6'h01;
    end
  end

  // frame words: stop, ninth or filler stop, then data, sent from bit 0
  wire logic [9:0] frame_nine = {1'b1, shift_s.data};
  wire logic [9:0] frame_eight = {2'h3, shift_s.data[7:0]};
  wire logic [3:0] left_load = nine_sel ? `AST_BITS_LEFT_NINE : `AST_BITS_LEFT_EIGHT;

  // shifter; losing the enable aborts the frame and idles the line
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ast_pkg::AST_ST_IDLE;
      shreg_r <= 10'h3ff;
      left_r <= 4'h0;
      tx_r <= 1'b1;
    end else if (!tx_run) begin
      state_r <= ast_pkg::AST_ST_IDLE;
      tx_r <= 1'b1;
    end else if (load) begin
      state_r <= ast_pkg::AST_ST_SEND;
      shreg_r <= nine_sel ? frame_nine : frame_eight;
      left_r <= left_load;
      tx_r <= 1'b0;
    end else if (frame_done) begin
      state_r <= ast_pkg::AST_ST_IDLE;
      tx_r <= 1'b1;
    end else if (bit_end) begin
      tx_r <= shreg_r[0];
      shreg_r <= {1'b1, shreg_r[9:1]};
      left_r <= left_r - 4'h1;
    end
  end

  // shift register empty: idle, even in the cycle that takes a byte from the buffer
  wire logic shift_empty = ~sending;

  // transmit flag and interrupt gating
  // the flag tells software that another byte may be written
  // the request is a plain level, gated by three enables

  // set on enable or on a load into the shifter; set beats the clear
  // that an accepted holding write makes
  wire logic flag_set = tx_en_rise | load;
  wire logic flag_nxt = flag_set ? 1'b1 : (hold_take ? 1'b0 : flag_r);

  // transmit flag
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // interrupt request needs all three enables
  assign tx_int_o = flag_r & pie_r[`AST_BIT_TX_INT_ENABLE] &
                    intctl_r[`AST_BIT_PERIPHERAL_INT_ENABLE] &
                    intctl_r[`AST_BIT_GLOBAL_INT_ENABLE];

  // read back
  // status bits are merged here rather than stored with software bits
  // read data is registered so the bus sees a stable value in the access cycle

  // flag and status bits merged into their registers
  wire ast_pkg::ast_byte_t pirf_rd = {pirf_r[7:5], flag_r, pirf_r[3:0]};
  wire ast_pkg::ast_byte_t transmit_status_control_rd = {transmit_status_control_r[7:2], shift_empty, transmit_status_control_r[0]};

  // holding register is write-only and reads as zero
  wire ast_pkg::ast_byte_t rd_byte =
    hit_intctl ? intctl_r :
    hit_pirf ? pirf_rd :
    hit_receive_status_control ? receive_status_control_r :
    hit_pie ? pie_r :
    hit_transmit_status_control ? transmit_status_control_rd :
    hit_baud ? baud_r :
    8'h00;

  // read data captured at the setup edge, held through the access cycle
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_r <= 32'h0000_0000;
    end else if (bus_setup) begin
      prdata_r <= {24'h00_0000, rd_byte};
    end
  end

  // outputs
  // the bus answers in the access cycle, so ready is tied high
  // the line idles high whenever the transmitter is stopped

  // zero wait states; error on an unmapped word or a write to a full buffer
  assign pready_o = 1'b1;
  assign pslverr_o = bus_access & (~hit_any | (wr_hold & ~hold_s.ready));
  assign prdata_o = prdata_r;

  // line driven only while the port is in asynchronous mode; a stopped
  // transmitter forces the idle level at once instead of one clock later
  assign tx_o = tx_r | ~tx_run;
  assign tx_oe_o = port_async;

endmodule

// File: sim/ast_top_props.sv
// concurrent checks on the serial transmitter top-level ports
`timescale 1ns/1ps
`include "ast_defs.svh"
module ast_top_props (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic tx_o,
  input wire logic tx_oe_o,
  input wire logic tx_int_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // access cycle of any transfer
  wire acc = psel_i && penable_i;
  // writes that change the interrupt enables
  wire wr_ic = acc && pwrite_i && paddr_i == {`AST_IDX_INTERRUPT_CONTROL, 2'b00};
  wire wr_pie = acc && pwrite_i && paddr_i == {`AST_IDX_PERIPHERAL_INT_ENABLES, 2'b00};
  // read of the write-only holding register
  wire rd_th = acc && !pwrite_i && paddr_i == {`AST_IDX_TRANSMIT_HOLDING, 2'b00};
  logic ge_r; // shadow of the global enable
  logic pe_r; // shadow of the peripheral enable
  logic te_r; // shadow of the local transmit enable
  // shadows follow software writes at the access edge
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ge_r <= 1'b0;
      pe_r <= 1'b0;
      te_r <= 1'b0;
    end else begin
      if (wr_ic) begin
        ge_r <= pwdata_i[`AST_BIT_GLOBAL_INT_ENABLE];
        pe_r <= pwdata_i[`AST_BIT_PERIPHERAL_INT_ENABLE];
      end
      if (wr_pie) begin
        te_r <= pwdata_i[`AST_BIT_TX_INT_ENABLE];
      end
    end
  end
  chk_ready_now: assert property (acc |-> pready_o)
    else $error("no ready in access cycle");
  chk_rdata_upper: assert property (prdata_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  chk_misalign_err: assert property (acc && paddr_i[1:0] != 2'b00 |-> pslverr_o)
    else $error("misaligned access without error");
  chk_err_access: assert property (pslverr_o |-> acc)
    else $error("error outside access cycle");
  chk_err_rdata: assert property (acc && !pwrite_i && pslverr_o |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  chk_hold_rd: assert property (rd_th |-> prdata_o == 32'h0)
    else $error("holding register read not zero");
  chk_idle_line: assert property (!tx_oe_o |-> tx_o)
    else $error("line low while port disabled");
  chk_start_min: assert property ($fell(tx_o) |-> (!tx_o || !tx_oe_o)[*8])
    else $error("start bit too short");
  chk_int_gated: assert property (tx_int_o |-> ge_r && pe_r && te_r)
    else $error("interrupt without all enables");
endmodule
bind ast_top ast_top_props u_props (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_o(tx_o),
  .tx_oe_o(tx_oe_o), .tx_int_o(tx_int_o));

// File: sim/ast_rx_model.sv
// remote receiver that samples the serial line at mid-bit and hands back whole frames
`timescale 1ns/1ps
module ast_rx_model (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic oe_i,
  input wire logic [15:0] per_i,
  input wire logic [3:0] nbits_i,
  output logic got_o,
  output logic [10:0] frame_o
);
  logic busy = 1'b0; // inside a frame
  int cnt = 0; // clocks to the next sample point
  int idx = 0; // bit position in the frame
  logic [10:0] acc = 11'h0; // frame collected so far
  assign frame_o = acc;
  // start found on first low; each bit sampled mid-way, so a wrong bit length drifts off
  always @(posedge clk_i) begin
    got_o <= 1'b0;
    if (!oe_i) begin
      busy <= 1'b0; // released line ends any frame
    end else if (!busy) begin
      if (!line_i) begin
        busy <= 1'b1;
        cnt <= per_i / 2;
        idx <= 0;
        acc <= 11'h0;
      end
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else begin
      acc[idx] <= line_i;
      cnt <= per_i - 1;
      idx <= idx + 1;
      if (idx == nbits_i + 1) begin
        busy <= 1'b0;
        got_o <= 1'b1;
      end
    end
  end
endmodule

// File: sim/ast_bench.sv
// self-checking bench: registers, interrupt gating, frames, buffer refusal and abort
`timescale 1ns/1ps
`include "ast_defs.svh"
module ast_bench;
  localparam logic [11:0] a_ic = {`AST_IDX_INTERRUPT_CONTROL, 2'b00};
  localparam logic [11:0] a_pir = {`AST_IDX_PERIPHERAL_INT_FLAGS, 2'b00};
  localparam logic [11:0] a_rcs = {`AST_IDX_RECEIVE_STATUS_CONTROL, 2'b00};
  localparam logic [11:0] a_th = {`AST_IDX_TRANSMIT_HOLDING, 2'b00};
  localparam logic [11:0] a_pie = {`AST_IDX_PERIPHERAL_INT_ENABLES, 2'b00};
  localparam logic [11:0] a_tsc = {`AST_IDX_TRANSMIT_STATUS_CONTROL, 2'b00};
  localparam logic [11:0] a_bd = {`AST_IDX_BAUD_DIVISOR, 2'b00};
  logic clk_i = 1'b0; // 200 MHz
  logic reset_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic tx_o;
  logic tx_oe_o;
  logic tx_int_o;
  logic [31:0] rd; // last read data
  logic er; // last error response
  logic [31:0] seed = 32'hd7612fd2;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [15:0] per = 16'h10; // clocks per bit now expected
  logic [3:0] nbits = 4'h8; // data bits per frame now expected
  logic got;
  logic [10:0] frame;
  logic [10:0] q[$]; // frames still owed by the line
  ast_top dut (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
    .tx_int_o(tx_int_o));
  ast_rx_model peer (.clk_i(clk_i), .line_i(tx_o), .oe_i(tx_oe_o), .per_i(per),
    .nbits_i(nbits), .got_o(got), .frame_o(frame));
  always #2.5 clk_i = ~clk_i;
  // xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected line frame, start bit first
  function automatic logic [10:0] fexp(input logic nine, input logic b8, input logic [7:0] d);
    return nine ? {1'b1, b8, d, 1'b0} : {2'b01, d, 1'b0};
  endfunction
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) @(posedge clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    #1;
  endtask
  // wait for the next decoded frame and compare it
  task automatic recv();
    @(posedge clk_i);
    while (got !== 1'b1) @(posedge clk_i);
    check(32'(frame), 32'(q.pop_front()));
  endtask
  // poll until the shifter reports empty
  task automatic wait_empty();
    apb(1'b0, a_tsc, 32'h0);
    while (rd[`AST_BIT_TX_SHIFT_EMPTY] !== 1'b1) apb(1'b0, a_tsc, 32'h0);
  endtask
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    logic [11:0] addrs [7];
    logic [7:0] rsts [7];
    int div;
    logic hs;
    logic nine;
    logic b8;
    addrs = '{a_ic, a_pir, a_rcs, a_th, a_pie, a_tsc, a_bd};
    rsts = '{`AST_RST_INTERRUPT_CONTROL, `AST_RST_PERIPHERAL_INT_FLAGS,
      `AST_RST_RECEIVE_STATUS_CONTROL, 8'h00, `AST_RST_PERIPHERAL_INT_ENABLES,
      `AST_RST_TRANSMIT_STATUS_CONTROL, `AST_RST_BAUD_DIVISOR};
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    foreach (addrs[i]) begin
      apb(1'b0, addrs[i], 32'h0);
      check(rd, 32'(rsts[i]));
    end
    apb(1'b1, a_rcs, 32'hff);
    apb(1'b0, a_rcs, 32'h0);
    check(rd, 32'hf0);
    apb(1'b1, a_tsc, 32'h09);
    apb(1'b0, a_tsc, 32'h0);
    check(rd, 32'h03);
    apb(1'b1, a_rcs, 32'h0);
    apb(1'b1, a_tsc, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    check(32'(er), 32'h1);
    apb(1'b1, 12'h265, 32'h55);
    check(32'(er), 32'h1);
    seed = xs(seed);
    apb(1'b1, a_bd, {24'h0, seed[7:0]});
    apb(1'b0, a_bd, 32'h0);
    check(rd, {24'h0, seed[7:0]});
    apb(1'b1, a_ic, {24'h0, seed[15:8]});
    apb(1'b0, a_ic, 32'h0);
    check(rd, {24'h0, seed[15:8]});
    apb(1'b0, a_pir, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, a_tsc, 32'h20);
    apb(1'b0, a_pir, 32'h0);
    check(rd, 32'h10);
    check(32'(tx_oe_o), 32'h0);
    apb(1'b1, a_rcs, 32'h80);
    check(32'(tx_oe_o), 32'h1);
    apb(1'b1, a_tsc, 32'h30);
    check(32'(tx_oe_o), 32'h0);
    apb(1'b1, a_tsc, 32'h20);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, a_ic, {24'h0, i[2], i[1], 6'h0});
      apb(1'b1, a_pie, {27'h0, i[0], 4'h0});
      check(32'(tx_int_o), 32'(i == 7));
    end
    apb(1'b1, a_ic, 32'h0);
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      div = (k == 0) ? 0 : int'(seed[1:0]);
      hs = k[0]; // both divider ranges are always covered
      nine = k[1]; // eight-bit and nine-bit frames are always covered
      b8 = seed[6];
      per = 16'((div + 1) * (hs ? 16 : 64));
      nbits = nine ? 4'h9 : 4'h8;
      apb(1'b1, a_bd, 32'(div));
      apb(1'b1, a_tsc, {24'h0, 1'b0, nine, 1'b1, 2'b00, hs, 1'b0, b8});
      q.push_back(fexp(nine, b8, seed[15:8]));
      apb(1'b1, a_th, {24'h0, seed[15:8]});
      recv();
      wait_empty();
    end
    apb(1'b1, a_bd, 32'h0);
    apb(1'b1, a_tsc, 32'h24);
    per = 16'h10;
    nbits = 4'h8;
    for (int k = 0; k < 6; k++) begin
      seed = xs(seed);
      apb(1'b1, a_th, {24'h0, seed[7:0]});
      check(32'(er), 32'(k == 5));
      if (k < 5) q.push_back(fexp(1'b0, 1'b0, seed[7:0]));
    end
    apb(1'b0, a_pir, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, a_tsc, 32'h0);
    check(rd, 32'h24);
    repeat (5) recv();
    apb(1'b0, a_pir, 32'h0);
    check(rd, 32'h10);
    wait_empty();
    apb(1'b1, a_th, 32'h0);
    repeat (40) @(posedge clk_i);
    apb(1'b1, a_rcs, 32'h0);
    check(32'(tx_o), 32'h1);
    check(32'(tx_oe_o), 32'h0);
    stop_test();
  end
endmodule
